// ===== rtl/bmt_pkg.sv
/*
  Shared constants of the break match and branch trace block: register map,
  field positions and trace record layout.
  Assumes a 32-bit APB master and a CPU on the same clock as the block.
*/
package bmt_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_B1_ADDR = 8'h00;
  localparam logic [7:0] OFS_B1_DATA = 8'h04;
  localparam logic [7:0] OFS_B1_CFG  = 8'h08;
  localparam logic [7:0] OFS_B1_CNT  = 8'h0c;
  localparam logic [7:0] OFS_B2_ADDR = 8'h10;
  localparam logic [7:0] OFS_B2_CFG  = 8'h14;
  localparam logic [7:0] OFS_B3_CFG  = 8'h18;
  localparam logic [7:0] OFS_CTRL    = 8'h1c;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_MASK    = 8'h24;
  localparam logic [7:0] OFS_TR_IDX  = 8'h28;
  localparam logic [7:0] OFS_TR_SRC  = 8'h2c;
  localparam logic [7:0] OFS_TR_DST  = 8'h30;
  localparam logic [7:0] OFS_TR_INFO = 8'h34;
  // Channel configuration fields.
  localparam int F_ADDRESS_SPACE_IDENTIFIER = 0;
  localparam int F_SZ   = 8;
  localparam int F_UA   = 10;
  localparam int F_UD   = 11;
  localparam int F_UI   = 12;
  localparam int F_URW  = 13;
  localparam int F_RWV  = 14;
  localparam int F_RWS  = 15;
  localparam int F_UBS  = 16;
  localparam int F_BSV  = 17;
  localparam int F_PC   = 19;
  localparam int CFG_W  = 20;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  // Control fields.
  localparam int C_BMASK = 0;
  localparam int C_RT    = 1;
  localparam int C_STOP  = 2;
  localparam int C_TREN  = 3;
  // Status and mask bits.
  localparam int S_BRK  = 0;
  localparam int S_FULL = 1;
  localparam int S_LOST = 2;
  localparam int CNT_W  = 12;
  // Trace record sizes in nibbles, header included.
  localparam logic [4:0] NIB_5  = 5'h0b;
  localparam logic [4:0] NIB_9  = 5'h0c;
  localparam logic [4:0] NIB_17 = 5'h0e;
  localparam logic [4:0] NIB_32 = 5'h11;
endpackage

// ===== rtl/bmt_core.sv
/*
  Break match channels, internal branch trace buffer and external trace
  port with APB registers and one interrupt line.
  Assumes CPU bus and branch signals are on pclk; the trace clock from
  the probe is asynchronous and is sampled here.
*/
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module bmt_core #(
  parameter int DEPTH = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_valid,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [31:0] cpu_pc,
  input  wire logic [31:0] cpu_data,
  input  wire logic [1:0]  bus_size,
  input  wire logic [7:0]  address_space_identifier,
  input  wire logic        bus_rd_n,
  input  wire logic        read_write_direction,
  input  wire logic [1:0]  bus_state,
  input  wire logic        io_access,
  input  wire logic        tlb_load_instruction,
  input  wire logic        branch_valid,
  input  wire logic [31:0] branch_src,
  input  wire logic [31:0] branch_dst,
  input  wire logic        nmi_req,
  output logic             break_req,
  output logic             nmi_accept,
  output logic             cpu_stall,
  input  wire logic        trace_clk,
  output logic [3:0]       trace_data,
  output logic             trace_sync_n,
  output logic             irq
);
  import bmt_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [31:0]          a1;
    logic [31:0]          d1;
    logic [31:0]          a2;
    logic [CFG_W-1:0]     c1;
    logic [CFG_W-1:0]     c2;
    logic [1:0]           c3;
    logic [CNT_W-1:0]     k1;
    logic [CNT_W-1:0]     n1;
    logic [3:0]           ctl;
    logic [2:0]           st;
    logic [2:0]           mk;
    logic                 halt;
    logic [AW-1:0]        idx;
    logic [DEPTH-1:0][63:0] tb;
    logic [AW-1:0]        wp;
    logic [AW:0]          cnt;
    logic [31:0]          prev;
    logic [67:0]          sh;
    logic [4:0]           nib;
    logic                 hd;
    logic [3:0]           tdat;
    logic                 tsyn_n;
    logic [2:0]           ck;
  } bmt_state_t;

  bmt_state_t q;
  bmt_state_t d;
  logic       wr;
  logic       rt;
  logic       take;
  logic       h1;
  logic       h2;
  logic       h3;
  logic       fire;
  logic       tick;
  logic [2:0] ev;

  // Compares one channel's enabled conditions against the current bus cycle.
  function automatic logic chan_hit(input logic [CFG_W-1:0] c, input logic [31:0] a,
                                    input logic [31:0] dv, input logic dok);
    logic [31:0] m;
    logic        any;
    m = (c[F_SZ+:2] == SZ_BYTE) ? 32'h000000ff :
        (c[F_SZ+:2] == SZ_WORD) ? 32'h0000ffff : 32'hffffffff;
    any = c[F_UA] | (dok & c[F_UD]) | c[F_UI] | c[F_URW] | c[F_UBS];
    chan_hit = bus_valid & any
      & (!c[F_UA] | ((c[F_PC] ? cpu_pc : cpu_addr) == a))
      & (!(dok & c[F_UD]) | (bus_size == c[F_SZ+:2]
         && (cpu_data & m) == (dv & m)))
      & (!c[F_UI] | (address_space_identifier == c[F_ADDRESS_SPACE_IDENTIFIER+:8]))
      & (!c[F_URW] | ((c[F_RWS] ? bus_rd_n : read_write_direction)
         == c[F_RWV]))
      & (!c[F_UBS] | (bus_state == c[F_BSV+:2]));
  endfunction

  // Channel hits; channel 2 has no data or count, channel 3 only two events.
  always_comb begin
    h1 = chan_hit(q.c1, q.a1, q.d1, 1'b1);
    h2 = chan_hit(q.c2, q.a2, 32'h00000000, 1'b0);
    h3 = (q.c3[0] & io_access) | (q.c3[1] & tlb_load_instruction);
  end

  // Handshake and derived control terms.
  assign wr         = psel & penable & pwrite;
  assign rt         = q.ctl[C_RT];
  assign tick       = q.ck[1] & ~q.ck[2];
  assign cpu_stall  = q.ctl[C_TREN] & branch_valid & (q.nib != 5'h00) & ~rt;
  assign take       = q.ctl[C_TREN] & branch_valid & ~cpu_stall;
  assign nmi_accept = q.halt & nmi_req & q.ctl[C_BMASK];
  assign break_req  = q.halt;
  assign trace_data   = q.tdat;
  assign trace_sync_n = q.tsyn_n;
  assign irq          = |(q.st & q.mk);
  assign pready       = 1'b1;

  // Next state of every register of the block.
  always_comb begin
    d    = q;
    fire = 1'b0;
    ev   = 3'h0;
    // Count on channel 1 decides whether its hit is a break.
    if (h1 && !q.halt) begin
      if (q.k1 == 12'h000) begin
        fire = 1'b1;
      end else if (q.n1 == q.k1 - 12'h001) begin
        fire = 1'b1;
        d.n1 = 12'h000;
      end else begin
        d.n1 = q.n1 + 12'h001;
      end
    end
    if ((h2 || h3) && !q.halt) begin
      fire = 1'b1;
    end
    // Halt on a break; leave it only through an accepted NMI.
    if (fire) begin
      d.halt = 1'b1;
      ev[S_BRK] = 1'b1;
    end else if (nmi_accept) begin
      d.halt = 1'b0;
    end
    // Internal trace buffer keeps every taken branch, except in stop mode once it is full.
    if (take) begin
      if (q.cnt == (AW+1)'(DEPTH) && q.ctl[C_STOP]) begin
        ev[S_FULL] = 1'b1;
      end else begin
        d.tb[q.wp] = {branch_src, branch_dst};
        d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
        if (q.cnt != (AW+1)'(DEPTH)) begin
          d.cnt = q.cnt + (AW+1)'(1);
        end
      end
    end
    // Trace clock is sampled twice before its edge is looked at.
    d.ck = {q.ck[1:0], trace_clk};
    if (tick) begin
      if (q.nib != 5'h00) begin
        d.tdat   = q.sh[67:64];
        d.tsyn_n = ~q.hd;
        d.hd     = 1'b0;
        d.sh     = {q.sh[63:0], 4'h0};
        d.nib    = q.nib - 5'h01;
      end else begin
        d.tdat   = 4'h0;
        d.tsyn_n = 1'b1;
      end
    end
    // A new record replaces any record still in flight.
    if (take) begin
      if (q.nib != 5'h00) begin
        ev[S_LOST] = 1'b1;
      end
      d.prev = branch_src;
      d.hd   = 1'b1;
      if (branch_src[31:4] == q.prev[31:4]) begin
        d.sh  = {4'h1, 3'h0, branch_src[4:0], branch_dst, 24'h000000};
        d.nib = NIB_5;
      end else if (branch_src[31:8] == q.prev[31:8]) begin
        d.sh  = {4'h2, 3'h0, branch_src[8:0], branch_dst, 20'h00000};
        d.nib = NIB_9;
      end else if (branch_src[31:16] == q.prev[31:16]) begin
        d.sh  = {4'h3, 3'h0, branch_src[16:0], branch_dst, 12'h000};
        d.nib = NIB_17;
      end else begin
        d.sh  = {4'h4, branch_src, branch_dst};
        d.nib = NIB_32;
      end
    end
    // Register writes; status bits clear by writing one, events win.
    if (wr) begin
      case (paddr)
        OFS_B1_ADDR: d.a1 = pwdata;
        OFS_B1_DATA: d.d1 = pwdata;
        OFS_B1_CFG:  d.c1 = pwdata[CFG_W-1:0];
        OFS_B1_CNT: begin
          d.k1 = pwdata[CNT_W-1:0];
          d.n1 = 12'h000;
        end
        OFS_B2_ADDR: d.a2 = pwdata;
        OFS_B2_CFG:  d.c2 = pwdata[CFG_W-1:0];
        OFS_B3_CFG:  d.c3 = pwdata[1:0];
        OFS_CTRL:    d.ctl = pwdata[3:0];
        OFS_STATUS:  d.st = q.st & ~pwdata[2:0];
        OFS_MASK:    d.mk = pwdata[2:0];
        OFS_TR_IDX:  d.idx = pwdata[AW-1:0];
        default: ;
      endcase
    end
    d.st = d.st | ev;
  end

  // Read mux and error answer for unmapped addresses.
  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      OFS_B1_ADDR: prdata = q.a1;
      OFS_B1_DATA: prdata = q.d1;
      OFS_B1_CFG:  prdata = {12'h000, q.c1};
      OFS_B1_CNT:  prdata = {20'h00000, q.k1};
      OFS_B2_ADDR: prdata = q.a2;
      OFS_B2_CFG:  prdata = {12'h000, q.c2};
      OFS_B3_CFG:  prdata = {30'h00000000, q.c3};
      OFS_CTRL:    prdata = {28'h0000000, q.ctl};
      OFS_STATUS:  prdata = {29'h00000000, q.st};
      OFS_MASK:    prdata = {29'h00000000, q.mk};
      OFS_TR_IDX:  prdata = 32'(q.idx);
      OFS_TR_SRC:  prdata = q.tb[q.idx][63:32];
      OFS_TR_DST:  prdata = q.tb[q.idx][31:0];
      OFS_TR_INFO: prdata = {q.halt, 15'h0000, 8'(q.cnt), 8'(q.wp)};
      default:     pslverr = psel & penable;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.tsyn_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Checks on the break channels.
  ch3_io_a: assert property (q.c3[0] && io_access && !q.halt |=> break_req)
    else $error("internal I/O access did not break");
  ch3_tlb_a: assert property (q.c3[1] && tlb_load_instruction && !q.halt
                              |=> break_req && q.st[S_BRK])
    else $error("TLB load did not break");
  nmi_resume_a: assert property (nmi_accept && !fire |=> !break_req)
    else $error("accepted NMI left the break standing");
  nmi_masked_a: assert property (q.halt && !q.ctl[C_BMASK] |=> q.halt)
    else $error("break ended without the mask bit");
  count_gate_a: assert property (q.k1 != 12'h000 && q.n1 < q.k1 - 12'h001 && !h2 && !h3
                                 && !q.halt |=> !break_req)
    else $error("break before the count was reached");
  // Checks on the trace.
  rt_nostall_a: assert property (rt |-> !cpu_stall)
    else $error("realtime trace stalled the CPU");
  nrt_stall_a: assert property (q.ctl[C_TREN] && !rt && branch_valid && q.nib != 5'h00
                                |-> cpu_stall)
    else $error("new branch not stalled while record in flight");
  stop_full_a: assert property (take && q.ctl[C_STOP] && q.cnt == (AW+1)'(DEPTH)
                                |=> $stable(q.wp) && q.st[S_FULL])
    else $error("stop mode wrote into a full buffer");
  cont_wrap_a: assert property (take && !q.ctl[C_STOP] |=> q.wp != $past(q.wp)
                                && q.cnt != 0)
    else $error("continue mode did not advance the write pointer");
  diff_five_a: assert property (take && branch_src[31:4] == q.prev[31:4]
                                |=> q.nib == NIB_5 && q.sh[67:64] == 4'h1)
    else $error("short source form not chosen");

  // Use bits of channel 1 and the terms under which a lone hit must break.
  logic [4:0] use1;
  logic       arm1;
  assign use1 = {q.c1[F_UBS], q.c1[F_URW], q.c1[F_UI], q.c1[F_UD], q.c1[F_UA]};
  assign arm1 = bus_valid && !q.halt && q.k1 == 12'h000;

  // A lone address condition breaks on a bus address match.
  addr_hit_a: assert property (arm1 && use1 == 5'h01 && !q.c1[F_PC]
                               && cpu_addr == q.a1 |=> break_req)
    else $error("bus address match did not break");

  // A lone address condition on the program counter breaks on a match.
  pc_hit_a: assert property (arm1 && use1 == 5'h01 && q.c1[F_PC]
                             && cpu_pc == q.a1 |=> break_req)
    else $error("program counter match did not break");

  // A lone data condition breaks when size and data both match.
  data_hit_a: assert property (arm1 && use1 == 5'h02 && bus_size == q.c1[F_SZ+:2]
                               && cpu_data == q.d1 |=> break_req)
    else $error("data match did not break");

  // A data condition never hits at another access size.
  data_size_a: assert property (use1 == 5'h02 && bus_size != q.c1[F_SZ+:2]
                                |-> !h1)
    else $error("data hit at the wrong access size");

  // A lone identifier condition breaks on an identifier match.
  address_space_identifier_hit_a: assert property (arm1 && use1 == 5'h04
                               && address_space_identifier == q.c1[F_ADDRESS_SPACE_IDENTIFIER+:8] |=> break_req)
    else $error("identifier match did not break");

  // A lone read/write condition breaks on a level match.
  rw_hit_a: assert property (arm1 && use1 == 5'h08 && q.c1[F_RWV]
                             == (q.c1[F_RWS] ? bus_rd_n : read_write_direction) |=> break_req)
    else $error("read/write level match did not break");

  // A lone bus state condition breaks on a state match.
  bstate_hit_a: assert property (arm1 && use1 == 5'h10
                                 && bus_state == q.c1[F_BSV+:2] |=> break_req)
    else $error("bus state match did not break");

  // Channel 2 ignores its data bit, so without other use bits it never hits.
  ch2_nodata_a: assert property (!q.c2[F_UA] && !q.c2[F_UI] && !q.c2[F_URW]
                                 && !q.c2[F_UBS] |-> !h2)
    else $error("channel 2 hit without a usable condition");

  // A channel with no use bits never hits.
  ch1_idle_a: assert property (use1 == 5'h00 |-> !h1)
    else $error("channel 1 hit with no condition enabled");

  // A break stands until an NMI is accepted.
  halt_hold_a: assert property (q.halt && !nmi_accept |=> break_req)
    else $error("break ended without an accepted NMI");

  // Every break that fires is also flagged in the status.
  brk_flag_a: assert property (fire |=> break_req && q.st[S_BRK])
    else $error("break fired without its status flag");

  // Realtime trace flags a record that a new branch cut short.
  lost_flag_a: assert property (take && rt && q.nib != 5'h00
                                |=> q.st[S_LOST])
    else $error("abandoned record not flagged");

  // The CPU is only stalled in non-realtime trace with a record in flight.
  stall_cause_a: assert property (cpu_stall |-> !rt && q.nib != 5'h00)
    else $error("CPU stalled without a record in flight");

  // Each stored branch lands in the slot the write pointer showed.
  buf_store_a: assert property (take && !q.ctl[C_STOP]
                                |=> q.tb[$past(q.wp)] == {$past(branch_src), $past(branch_dst)})
    else $error("branch not stored at the write pointer");

  // Continue mode keeps the buffer full while it overwrites.
  cont_full_a: assert property (take && !q.ctl[C_STOP] && q.cnt == (AW+1)'(DEPTH)
                                |=> q.cnt == (AW+1)'(DEPTH))
    else $error("continue mode lost its full count");

  // Stop mode leaves every entry of a full buffer untouched.
  stop_keep_a: assert property (take && q.ctl[C_STOP] && q.cnt == (AW+1)'(DEPTH)
                                |=> q.tb == $past(q.tb))
    else $error("stop mode changed a full buffer");

  // The header nibble goes out with the sync pin low.
  head_sync_a: assert property (tick && q.hd && q.nib != 5'h00 |=> !q.tsyn_n)
    else $error("header nibble sent without sync");

  // With no record left the pins go idle.
  idle_pins_a: assert property (tick && q.nib == 5'h00
                                |=> q.tsyn_n && q.tdat == 4'h0)
    else $error("trace pins not idle after the record");
endmodule

// ===== dv/bmt_probe.sv
/*
  Trace probe model: makes the trace clock only inside frames and
  collects the nibbles that the block puts on the trace pins.
  Assumes each nibble settles well within one trace clock period.
*/
`timescale 1ns/1ps
module bmt_probe (
  input  wire logic [3:0] trace_data,
  input  wire logic       trace_sync_n,
  output logic            trace_clk
);
  logic [3:0]   hdr;
  logic [127:0] sr;

  // The clock stands low outside frames.
  initial begin
    trace_clk = 1'b0;
    sr = '0;
  end

  // Runs k periods; each nibble is taken just before the next rise.
  task automatic frame(input int k);
    #37;
    repeat (k) begin
      trace_clk = 1'b1;
      #400;
      trace_clk = 1'b0;
      #400;
      if (!trace_sync_n) begin
        hdr = trace_data;
        sr = '0;
      end else begin
        sr = {sr[123:0], trace_data};
      end
    end
  endtask
endmodule

// ===== dv/break_match_and_branch_trace_test.sv
/*
  Self-checking bench of the break match and branch trace block.
  Assumes the probe model of bmt_probe.sv on the trace pins.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module break_match_and_branch_trace_test;
  import bmt_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr, id;
  logic [31:0]  pwdata, prdata, ca, pc, cd, bs, bd, ra, c, da, db;
  logic [1:0]   sz, bst;
  logic         bv, rdn, rw, io, tlb, brv, nmi, brk, nacc, stall, tclk, tsync_n, irq;
  logic [3:0]   tdat;
  logic [109:0] hv;
  logic [32:0]  q[$];
  logic [32:0]  e;
  int           error_cnt, compares;

  bmt_core #(.DEPTH(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_valid(bv), .cpu_addr(ca), .cpu_pc(pc), .cpu_data(cd), .bus_size(sz),
    .address_space_identifier(id), .bus_rd_n(rdn), .read_write_direction(rw),
    .bus_state(bst), .io_access(io), .tlb_load_instruction(tlb), .branch_valid(brv),
    .branch_src(bs), .branch_dst(bd), .nmi_req(nmi), .break_req(brk), .nmi_accept(nacc),
    .cpu_stall(stall), .trace_clk(tclk), .trace_data(tdat), .trace_sync_n(tsync_n),
    .irq(irq));
  bmt_probe u_probe (.trace_data(tdat), .trace_sync_n(tsync_n), .trace_clk(tclk));

  // The clock toggles every half period.
  always #50 pclk = ~pclk;

  // Read results are compared with the oldest note when the access phase ends.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      `CHK({pslverr, prdata}, e)
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A wait that used up its bound ends the run as a failure.
  task automatic tmo(input int n);
    if (n >= 400) begin
      error_cnt++;
      stop_test();
    end
  endtask

  // One APB transfer, held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 400);
    psel    <= 1'b0;
    penable <= 1'b0;
    tmo(n);
  endtask

  // Notes the expected {pslverr, prdata} and reads.
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask

  // One cycle of bus attributes and event strobes, then the break level.
  task automatic pulse(input logic [2:0] m, input logic [109:0] h, input logic x);
    @(posedge pclk);
    {ca, pc, cd, sz, id, rdn, rw, bst} <= h;
    {tlb, io, bv} <= m;
    @(posedge pclk);
    {ca, pc, cd, sz, id, rdn, rw, bst} <= '0;
    {tlb, io, bv} <= 3'h0;
    @(negedge pclk);
    `CHK(brk, x)
  endtask

  // Leaves the break through an NMI and clears the sticky break status bit.
  task automatic release_brk;
    `CHK(irq, 1'b1)
    @(posedge pclk);
    nmi <= 1'b1;
    @(negedge pclk);
    `CHK(nacc, 1'b1)
    @(posedge pclk);
    nmi <= 1'b0;
    @(negedge pclk);
    `CHK(brk, 1'b0)
    apb(1'b1, OFS_STATUS, 32'h1);
    @(negedge pclk);
    `CHK(irq, 1'b0)
  endtask

  // Offers a branch and holds it while the CPU is stalled.
  task automatic br(input logic [31:0] s, input logic [31:0] d);
    logic hold;
    int   n;
    @(posedge pclk);
    brv <= 1'b1;
    bs  <= s;
    bd  <= d;
    n = 0;
    do begin
      @(negedge pclk);
      hold = stall;
      @(posedge pclk);
      n++;
    end while (hold !== 1'b0 && n < 400);
    brv <= 1'b0;
    tmo(n);
  endtask

  // Main sequence: reset, break channels, then trace.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    error_cnt = 0;
    compares = 0;
    {psel, penable, pwrite, paddr, pwdata, bv, ca, pc, cd, sz, id, rdn, rw, bst} = '0;
    {io, tlb, brv, bs, bd, nmi} = '0;
    ra = $urandom(76944);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_STATUS, 33'h0);
    rd(8'h3c, 33'h1_0000_0000);
    `CHK(tsync_n, 1'b1)
    $display("reset test done");
    ra = $urandom | 32'h1;
    apb(1'b1, OFS_MASK, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_B1_ADDR, ra);
    apb(1'b1, OFS_B1_DATA, ra);
    apb(1'b1, OFS_B2_ADDR, ra);
    for (int k = 0; k < 6; k++) begin
      case (k)
        0: c = 32'h1 << F_UA;
        1: c = (32'h1 << F_UA) | (32'h1 << F_PC);
        2: c = (32'h1 << F_UD) | (32'(SZ_WORD) << F_SZ);
        3: c = (32'h1 << F_UI) | {24'h0, ra[7:0] | 8'h1};
        4: c = (32'h1 << F_URW) | (32'h1 << F_RWV) | (32'h1 << F_RWS);
        default: c = (32'h1 << F_UBS) | (32'h2 << F_BSV);
      endcase
      case (k)
        0: hv = {ra, 78'h0};
        1: hv = {~ra, ra, 46'h0};
        2: hv = {64'h0, ra, SZ_WORD, 12'h0};
        3: hv = {98'h0, ra[7:0] | 8'h1, 4'h0};
        4: hv = {106'h0, 4'h8};
        default: hv = {108'h0, 2'h2};
      endcase
      apb(1'b1, OFS_B1_CFG, c);
      pulse(3'h1, '0, 1'b0);
      pulse(3'h1, hv, 1'b1);
      release_brk();
    end
    apb(1'b1, OFS_B1_CFG, 32'h0);
    apb(1'b1, OFS_B2_CFG, 32'h1 << F_UD);
    pulse(3'h1, {ra, ra, ra, 14'h0}, 1'b0);
    apb(1'b1, OFS_B2_CFG, 32'h1 << F_UA);
    pulse(3'h1, {ra, 78'h0}, 1'b1);
    release_brk();
    apb(1'b1, OFS_B2_CFG, 32'h0);
    apb(1'b1, OFS_B3_CFG, 32'h1);
    pulse(3'h2, '0, 1'b1);
    release_brk();
    apb(1'b1, OFS_B3_CFG, 32'h2);
    pulse(3'h2, '0, 1'b0);
    pulse(3'h4, '0, 1'b1);
    release_brk();
    apb(1'b1, OFS_B3_CFG, 32'h0);
    apb(1'b1, OFS_B1_CFG, 32'h1 << F_UA);
    apb(1'b1, OFS_B1_CNT, 32'h3);
    repeat (2) pulse(3'h1, {ra, 78'h0}, 1'b0);
    pulse(3'h1, {ra, 78'h0}, 1'b1);
    release_brk();
    apb(1'b1, OFS_B1_CFG, 32'h0);
    $display("break tests done");
    da = $urandom;
    db = $urandom;
    apb(1'b1, OFS_CTRL, 32'h9);
    br(32'h12, da);
    fork
      br(32'h1234, db);
      begin
        repeat (2) @(posedge pclk);
        u_probe.frame(12);
      end
      begin
        @(posedge pclk);
        @(negedge pclk);
        `CHK(stall, 1'b1)
      end
    join
    `CHK(u_probe.hdr, 4'h2)
    `CHK(u_probe.sr[43:0], {12'h012, da})
    repeat (4) @(posedge pclk);
    u_probe.frame(15);
    `CHK(u_probe.hdr, 4'h3)
    `CHK(u_probe.sr[55:0], {20'h01234, db, 4'h0})
    apb(1'b1, OFS_CTRL, 32'hb);
    br(32'h5678, da);
    fork
      br(32'h5690, db);
      begin
        @(posedge pclk);
        @(negedge pclk);
        `CHK(stall, 1'b0)
      end
    join
    rd(OFS_STATUS, 33'h4);
    apb(1'b1, OFS_STATUS, 32'h4);
    br(32'h9abc, da);
    apb(1'b1, OFS_TR_IDX, 32'h0);
    rd(OFS_TR_SRC, 33'h9abc);
    apb(1'b1, OFS_CTRL, 32'hf);
    br(32'hdef0, db);
    rd(OFS_STATUS, 33'h6);
    apb(1'b1, OFS_TR_IDX, 32'h1);
    rd(OFS_TR_SRC, 33'h1234);
    rd(OFS_TR_DST, {1'b0, db});
    $display("trace tests done");
    stop_test();
  end
endmodule
